// ===== data_port_regs.svh
// Purpose: Register map, field positions, reset values and timing figures
// Assumes: 32-bit register port, 50 MHz clock
// Notes: Definitions only
`ifndef DATA_PORT_REGS_SVH
`define DATA_PORT_REGS_SVH

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_CTS_DELAY 8'h04
`define REG_HOLD 8'h08
`define REG_SECURITY 8'h0c
`define REG_STATUS 8'h10

// Control register fields
`define CTRL_BUF_BIT 0
`define CTRL_KEY_BIT 1
`define CTRL_MASTER_BIT 2

// Hold register: flag bit meaning not applicable in modem mode
`define HOLD_NA_BIT 16
`define HOLD_MAX 16'hea60
`define HOLD_RESET 16'h0000
`define CTS_DELAY_RESET 8'h00
`define SECURITY_NONE 8'h00

// Millisecond tick, derived from the clock period
`define MS_NS 1000000
`define CLK_NS 20
`define TICK_CYCLES (`MS_NS / `CLK_NS)

`endif

// ===== data_port_pkg.sv
// Purpose: Types shared by the data port control logic
// Assumes: Constants live in data_port_regs.svh
// Notes: Keyline states are Gray coded along idle, key-up, send, hold
package data_port_pkg;
  typedef enum logic [1:0] {
    KEY_IDLE = 2'b00,
    KEY_UP = 2'b01,
    KEY_SEND = 2'b11,
    KEY_HOLD = 2'b10
  } key_state_e;
  typedef logic [7:0] addr_t;
  typedef logic [31:0] word_t;
endpackage

// ===== data_port_handshake_buffering.sv
// Purpose: Payload port release, buffering and RTS/CTS handshake control
// Assumes: Single 50 MHz clock, synchronous active-low reset
// Notes: Received radio bytes pass an 8-word FIFO before the port
//
// Overview of operation
// [R1] Buffering off: bytes go to the port as soon as frames arrive.
// [R2] Buffering on: hold data until a whole packet, then send gap-free. A full 8-word FIFO releases a longer packet early.
// [R3] Attached equipment keeps buffered messages at 256 characters or less.
// [R4] Buffering changes only port delivery timing, never radio transmission.
// [R5] Only a master writes the buffer setting; remotes take the broadcast.
// [R6] Security is none or 1 to 255, none at reset; nonzero encrypts.
// [R7] Reading security shows only active or inactive, never the value.
// [R8] A remote with a security value unlike the master's never synchronizes.
// [R9] Clear-to-send delay is 0 to 255 ms and times the CTS response.
// [R10] Modem mode raises CTS after the delay from RTS; zero is immediate.
// [R11] Keyline mode ignores RTS and uses CTS to key another radio.
// [R12] Keyline mode raises CTS at once when radio data is received.
// [R13] Keyline mode withholds port output until the key-up delay ends.
// [R14] Keyline CTS stays up for hold time after the last character.
// [R15] Reading hold time in modem mode returns a not-applicable flag.
// [R16] Modem mode is the reset default; port characters key the transmitter.
// [R17] Modem mode drops CTS while the radio cannot keep up.
// [R18] A millisecond tick counts both delays; counters reload on triggers.
//
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "data_port_regs.svh"

module byte_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  // Full and empty come straight from the occupancy count
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign count = cnt_q;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer, count and storage next values
  always_comb begin
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = in_data;
      wr_d = (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
    mem_q <= mem_d;
  end
endmodule

module data_port_handshake_buffering
  import data_port_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_CYCLES,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire addr_t reg_addr,
  input wire word_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output word_t reg_rdata,
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  output logic out_valid,
  input wire logic out_ready,
  output logic [7:0] out_data,
  input wire logic port_tx_idle,
  input wire logic rts_pin,
  output logic cts_pin,
  input wire logic port_rx_valid,
  input wire logic radio_tx_ready,
  output logic key_tx,
  input wire logic bcast_valid,
  input wire logic bcast_buffer_mode,
  input wire logic sync_seen,
  input wire logic [7:0] heard_code,
  input wire logic sync_lost,
  output logic synced,
  output logic encrypt_en
);
  localparam int AW = $clog2(DEPTH);
  localparam int TW = $clog2(TICK_CYCLES);

  logic packet_buffer_mode_q, packet_buffer_mode_d;
  logic keyline_q, keyline_d, master_q, master_d;
  logic [7:0] cts_delay_q, cts_delay_d, security_q, security_d;
  logic [15:0] clear_hold_time_q, clear_hold_time_d;
  word_t rdata_q, rdata_d;
  logic synced_q, synced_d;
  logic modem_mode;

  // Software writes decode the offset, one match per strobe
  function automatic logic hit(input addr_t a, input addr_t off);
    hit = (a == off);
  endfunction

  assign modem_mode = !keyline_q;

  // Register file: writes, broadcasts and sync qualification
  always_comb begin
    packet_buffer_mode_d = packet_buffer_mode_q;
    keyline_d = keyline_q;
    master_d = master_q;
    cts_delay_d = cts_delay_q;
    clear_hold_time_d = clear_hold_time_q;
    security_d = security_q;
    synced_d = synced_q;
    if (reg_wr && hit(reg_addr, `REG_CTRL)) begin
      keyline_d = reg_wdata[`CTRL_KEY_BIT];
      master_d = reg_wdata[`CTRL_MASTER_BIT];
      if (master_q) begin
        packet_buffer_mode_d = reg_wdata[`CTRL_BUF_BIT]; // R5
      end
    end
    if (!master_q && bcast_valid) begin
      packet_buffer_mode_d = bcast_buffer_mode; // R5
    end
    if (reg_wr && hit(reg_addr, `REG_CTS_DELAY)) begin
      cts_delay_d = reg_wdata[7:0]; // R9
    end
    // Compare the whole word so large writes clamp rather than wrap
    if (reg_wr && hit(reg_addr, `REG_HOLD)) begin
      clear_hold_time_d = reg_wdata[15:0];
      if (reg_wdata > {16'h0000, `HOLD_MAX}) begin
        clear_hold_time_d = `HOLD_MAX; // R14
      end
    end
    if (reg_wr && hit(reg_addr, `REG_SECURITY)) begin
      security_d = reg_wdata[7:0]; // R6
    end
    // A heard master only counts when its code equals ours
    if (sync_lost) begin
      synced_d = 1'b0;
    end
    if (sync_seen) begin
      synced_d = (heard_code == security_q); // R8
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      packet_buffer_mode_q <= 1'b0;
      keyline_q <= 1'b0; // R16
      master_q <= 1'b0;
      cts_delay_q <= `CTS_DELAY_RESET;
      clear_hold_time_q <= `HOLD_RESET;
      security_q <= `SECURITY_NONE; // R6
      synced_q <= 1'b0;
    end else begin
      packet_buffer_mode_q <= packet_buffer_mode_d;
      keyline_q <= keyline_d;
      master_q <= master_d;
      cts_delay_q <= cts_delay_d;
      clear_hold_time_q <= clear_hold_time_d;
      security_q <= security_d;
      synced_q <= synced_d;
    end
  end

  assign encrypt_en = (security_q != `SECURITY_NONE); // R6
  assign synced = synced_q;

  // RTS arrives from the pin, so it passes two flops first
  logic rts_meta_q, rts_s_q, rts_old_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rts_meta_q <= 1'b0;
      rts_s_q <= 1'b0;
      rts_old_q <= 1'b0;
    end else begin
      rts_meta_q <= rts_pin;
      rts_s_q <= rts_meta_q;
      rts_old_q <= rts_s_q;
    end
  end

  // Receive path: byte plus end-of-packet flag in the FIFO
  logic [8:0] fifo_out;
  logic fifo_out_valid, pop;
  logic [AW:0] fifo_count;
  logic fifo_full;
  byte_fifo #(.WIDTH(9), .DEPTH(DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(rx_valid),
    .in_ready(rx_ready),
    .in_data({rx_last, rx_data}),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_out),
    .count(fifo_count)
  );
  assign fifo_full = !rx_ready;

  // Keyline sequencer, millisecond prescaler and shared delay counter
  key_state_e state_q, state_d;
  logic [TW-1:0] pre_q, pre_d;
  logic [15:0] cnt_q, cnt_d;
  logic tick, load, mdone_q, mdone_d, cts_q, cts_d;
  logic [AW:0] pkt_q, pkt_d;
  logic drain_q, drain_d, release_ok, port_go;
  logic push_last, pop_last, rx_seen;

  assign tick = (pre_q == TW'(TICK_CYCLES-1)); // R18
  assign rx_seen = rx_valid || fifo_out_valid;
  assign push_last = rx_valid && rx_ready && rx_last;
  assign pop_last = pop && fifo_out[8];

  // Buffered release waits for a whole packet; a full FIFO forces release
  assign release_ok = !packet_buffer_mode_q || (pkt_q != '0) || drain_q ||
                      fifo_full; // R2
  assign port_go = modem_mode || (state_q == KEY_SEND); // R13
  assign out_valid = fifo_out_valid && release_ok && port_go; // R1
  assign out_data = fifo_out[7:0];
  assign pop = out_valid && out_ready;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    mdone_d = mdone_q;
    load = 1'b0;
    pkt_d = pkt_q;
    drain_d = drain_q;
    if (push_last && !pop_last) begin
      pkt_d = pkt_q + 1'b1;
    end else if (pop_last && !push_last) begin
      pkt_d = pkt_q - 1'b1;
    end
    if (pop) begin
      drain_d = !fifo_out[8]; // Once started, a packet leaves unbroken
    end
    if (modem_mode) begin
      state_d = KEY_IDLE; // R11
      if (rts_s_q && !rts_old_q) begin
        load = 1'b1; // R18
        cnt_d = {8'h00, cts_delay_q};
        mdone_d = (cts_delay_q == 8'h00); // R10
      end else if (!rts_s_q) begin
        mdone_d = 1'b0;
      end else if (!mdone_q && tick) begin
        cnt_d = cnt_q - 16'h0001;
        mdone_d = (cnt_q == 16'h0001); // R9
      end
    end else begin
      mdone_d = 1'b0;
      unique case (state_q)
        KEY_IDLE: begin
          if (rx_seen) begin
            load = 1'b1;
            cnt_d = {8'h00, cts_delay_q};
            state_d = (cts_delay_q == 8'h00) ? KEY_SEND : KEY_UP; // R12
          end
        end
        KEY_UP: begin
          if (tick) begin
            cnt_d = cnt_q - 16'h0001;
            if (cnt_q == 16'h0001) begin
              state_d = KEY_SEND; // R13
            end
          end
        end
        KEY_SEND: begin
          if (!rx_seen && port_tx_idle) begin
            load = 1'b1;
            cnt_d = clear_hold_time_q;
            state_d = (clear_hold_time_q == 16'h0000) ? KEY_IDLE
                                                      : KEY_HOLD; // R14
          end
        end
        KEY_HOLD: begin
          if (rx_seen) begin
            state_d = KEY_SEND; // Still keyed, no new key-up wait
          end else if (tick) begin
            cnt_d = cnt_q - 16'h0001;
            if (cnt_q == 16'h0001) begin
              state_d = KEY_IDLE; // R14
            end
          end
        end
      endcase
    end
    // Prescaler restarts on each trigger so delays are exact in ms
    pre_d = (load || tick) ? '0 : pre_q + 1'b1;
    if (modem_mode) begin
      cts_d = rts_s_q && mdone_d && radio_tx_ready; // R10 R17
    end else begin
      cts_d = (state_d != KEY_IDLE); // R11
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= KEY_IDLE;
      pre_q <= '0;
      cnt_q <= 16'h0000;
      mdone_q <= 1'b0;
      cts_q <= 1'b0;
      pkt_q <= '0;
      drain_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pre_q <= pre_d;
      cnt_q <= cnt_d;
      mdone_q <= mdone_d;
      cts_q <= cts_d;
      pkt_q <= pkt_d;
      drain_q <= drain_d;
    end
  end
  assign cts_pin = cts_q;

  // Transmit keying follows port characters in modem mode only, whatever the buffering
  logic key_q, key_d;
  always_comb begin
    key_d = modem_mode && port_rx_valid; // R16 R4
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      key_q <= 1'b0;
    end else begin
      key_q <= key_d;
    end
  end
  assign key_tx = key_q;

  // Read data: answered one cycle after the strobe, zero otherwise
  always_comb begin
    rdata_d = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        `REG_CTRL: begin
          rdata_d[`CTRL_BUF_BIT] = packet_buffer_mode_q &&
                                   (master_q || synced_q); // R5
          rdata_d[`CTRL_KEY_BIT] = keyline_q;
          rdata_d[`CTRL_MASTER_BIT] = master_q;
        end
        `REG_CTS_DELAY: rdata_d[7:0] = cts_delay_q;
        `REG_HOLD: begin
          if (modem_mode) begin
            rdata_d[`HOLD_NA_BIT] = 1'b1; // R15
          end else begin
            rdata_d[15:0] = clear_hold_time_q;
          end
        end
        `REG_SECURITY: rdata_d[0] = encrypt_en; // R7
        `REG_STATUS: rdata_d = {23'h000000, 4'(fifo_count), 1'b0,
                                state_q, synced_q, cts_q};
        default: rdata_d = '0;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end
  assign reg_rdata = rdata_q;

  // Checks on the handshake, release and register behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_NOBUF_FLOW: assert property ( // R1
    !packet_buffer_mode_q && modem_mode && fifo_out_valid |-> out_valid)
    else $error("Unbuffered data held back");
  AST_BUF_WAIT: assert property ( // R2
    packet_buffer_mode_q && pkt_q == '0 && !drain_q && !fifo_full
    |-> !out_valid)
    else $error("Partial packet released");
  AST_REMOTE_LOCK: assert property ( // R5
    reg_wr && hit(reg_addr, `REG_CTRL) && !master_q && !bcast_valid
    |=> $stable(packet_buffer_mode_q))
    else $error("Remote changed buffer setting");
  AST_SYNC_CODE: assert property ( // R8
    sync_seen && heard_code != security_q |=> !synced)
    else $error("Synchronized with wrong code");
  AST_SEC_HIDDEN: assert property ( // R7
    reg_rd && reg_addr == `REG_SECURITY |=> reg_rdata[31:1] == '0)
    else $error("Security value exposed");
  AST_MODEM_DELAY: assert property ( // R9
    modem_mode && rts_s_q && !rts_old_q && cts_delay_q != 8'h00
    |=> !cts_pin [*2])
    else $error("CTS before delay");
  AST_MODEM_ZERO: assert property ( // R10
    modem_mode && rts_s_q && !rts_old_q && cts_delay_q == 8'h00 &&
    radio_tx_ready |=> cts_pin)
    else $error("Zero delay CTS late");
  AST_KEY_IGNORE_RTS: assert property ( // R11
    !modem_mode && state_q == KEY_IDLE && !rx_seen |=> !cts_pin)
    else $error("Keyline CTS without data");
  AST_KEY_CTS: assert property ( // R12
    !modem_mode && state_q == KEY_IDLE && rx_valid |=> cts_pin)
    else $error("Keyline CTS not raised");
  AST_KEYUP_QUIET: assert property ( // R13
    state_q == KEY_UP |-> !out_valid)
    else $error("Output during key-up");
  AST_HOLD_ZERO: assert property ( // R14
    state_q == KEY_SEND && !modem_mode && !rx_seen && port_tx_idle &&
    clear_hold_time_q == 16'h0000 |=> state_q == KEY_IDLE && !cts_pin)
    else $error("CTS held with zero hold");
  AST_HOLD_NA: assert property ( // R15
    reg_rd && reg_addr == `REG_HOLD && modem_mode
    |=> reg_rdata[`HOLD_NA_BIT] && reg_rdata[15:0] == 16'h0000)
    else $error("Hold time shown in modem mode");
  AST_KEY_TX: assert property ( // R16
    modem_mode && port_rx_valid |=> key_tx)
    else $error("Port data did not key");
  AST_FLOW_STOP: assert property ( // R17
    modem_mode && !radio_tx_ready |=> !cts_pin)
    else $error("CTS kept while radio busy");
  AST_TICK_RANGE: assert property ( // R18
    pre_q <= TW'(TICK_CYCLES-1))
    else $error("Prescaler overran");

  COV_BUF_PACKET: cover property (packet_buffer_mode_q && pop_last);
  COV_KEY_HOLD: cover property (state_q == KEY_HOLD ##1 state_q == KEY_IDLE);
  COV_MODEM_CTS: cover property (modem_mode && !cts_pin ##1 cts_pin);
  COV_FIFO_FULL: cover property (fifo_full);
endmodule

// ===== port_partner.sv
// Purpose: Terminal model on the far side of the payload port
// Assumes: Each accepted character keeps the serializer busy 3 cycles
// Notes: stall holds the terminal off so the FIFO fills up
`timescale 1ns/1ps
module port_partner (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  input wire logic stall,
  input wire logic rts_req,
  output logic out_ready,
  output logic port_tx_idle,
  output logic rts_pin
);
  logic [1:0] busy_q;
  logic [7:0] got[$];

  // Take a byte only with the serializer empty and not held off
  assign out_ready = !stall && busy_q == 2'h0;
  assign port_tx_idle = busy_q == 2'h0;
  // RTS is a level the terminal holds, following rts_req from the bench
  assign rts_pin = rts_req;

  // Log each character as it leaves, then count its frame time
  always @(posedge clk) begin
    if (!rst_n) begin
      busy_q <= 2'h0;
    end else if (out_valid && out_ready) begin
      busy_q <= 2'h3;
      got.push_back(out_data);
    end else if (busy_q != 2'h0) begin
      busy_q <= busy_q - 2'h1;
    end
  end
endmodule

// ===== data_port_handshake_buffering_tb.sv
// Purpose: Self-checking bench for payload release and RTS/CTS control
// Assumes: Millisecond tick shortened to 4 cycles
// Notes: Register cases run from a table; streams and handshake by hand
`timescale 1ns/1ps
`include "data_port_regs.svh"
module data_port_handshake_buffering_tb
  import data_port_pkg::*;
  ;
  localparam int TK = 4;
  typedef struct packed {
    addr_t a;
    word_t d;
    word_t e;
  } row_s;
  logic clk, rst_n, reg_wr, reg_rd, rx_valid, rx_ready, rx_last;
  logic out_valid, out_ready, port_tx_idle, rts_pin, rts_req, cts_pin;
  logic port_rx_valid, radio_tx_ready, key_tx, bcast_valid, stall;
  logic bcast_buffer_mode, sync_seen, sync_lost, synced, encrypt_en;
  addr_t reg_addr;
  word_t reg_wdata, reg_rdata, rd_w;
  logic [7:0] rx_data, out_data, heard_code, nb;
  logic [7:0] exp_q[$];
  int n_fail, checks, gaps;
  // Address, value written, value read back
  row_s rows[10] = '{
    '{`REG_CTRL, 32'h1, 32'h0},
    '{`REG_CTRL, 32'h4, 32'h4},
    '{`REG_CTRL, 32'h5, 32'h5},
    '{`REG_CTRL, 32'h4, 32'h4},
    '{`REG_CTS_DELAY, 32'hff, 32'hff},
    '{`REG_SECURITY, 32'h5a, 32'h1},
    '{`REG_HOLD, 32'h64, 32'h10000},
    '{8'h14, 32'hffffffff, 32'h0},
    '{`REG_SECURITY, 32'h0, 32'h0},
    '{`REG_STATUS, 32'h0, 32'h0}
  };

  data_port_handshake_buffering #(.TICK_CYCLES(TK), .DEPTH(8)) dut_u (
    .clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .rx_valid, .rx_ready, .rx_data, .rx_last, .out_valid, .out_ready,
    .out_data, .port_tx_idle, .rts_pin, .cts_pin, .port_rx_valid,
    .radio_tx_ready, .key_tx, .bcast_valid, .bcast_buffer_mode,
    .sync_seen, .heard_code, .sync_lost, .synced, .encrypt_en
  );
  port_partner partner_u (
    .clk, .rst_n, .out_valid, .out_data, .stall, .rts_req, .out_ready,
    .port_tx_idle, .rts_pin
  );

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // The run needs a few hundred cycles; this only cuts a hang short
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    wrap_up();
  end

  task automatic chk_w(input word_t g, input word_t e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_b(input logic g, input logic e);
    chk_w({31'h0, g}, {31'h0, e});
  endtask
  // Let edges pass, then look once their updates have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input addr_t a, input word_t d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk) reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input addr_t a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk) reg_rd <= 1'b0;
    #1 rd_w = reg_rdata;
  endtask
  // Back-to-back bytes; packets stay far below 256 characters
  task automatic send(input int n, input logic last);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data <= nb;
      rx_last <= last && i == n - 1;
      exp_q.push_back(nb);
      nb = nb + 8'h01;
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
  endtask
  // Wait for the terminal to hold every byte, then compare in order
  task automatic drain();
    int k;
    k = 0;
    while (partner_u.got.size() < exp_q.size() && k < 200) begin
      cyc(1);
      k++;
    end
    chk_w(word_t'(partner_u.got.size()), word_t'(exp_q.size()));
    foreach (exp_q[i]) begin
      chk_w(word_t'(partner_u.got[i]), word_t'(exp_q[i]));
    end
    exp_q.delete();
    partner_u.got.delete();
  endtask
  task automatic sync(input logic [7:0] c, input logic lost);
    @(posedge clk);
    sync_seen <= ~lost;
    sync_lost <= lost;
    heard_code <= c;
    @(posedge clk);
    sync_seen <= 1'b0;
    sync_lost <= 1'b0;
    cyc(1);
  endtask
  task automatic done(input string s);
    $display("test %s ended, %0d mismatches so far", s, n_fail);
  endtask
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    {reg_wr, reg_rd, rx_valid, rx_last, rts_req, stall} = 6'h0;
    {port_rx_valid, bcast_valid, bcast_buffer_mode} = 3'h0;
    {sync_seen, sync_lost} = 2'h0;
    radio_tx_ready = 1'b1;
    rx_data = 8'h00;
    heard_code = 8'h00;
    nb = 8'h10;
    n_fail = 0;
    checks = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    // Reset state: modem mode, no security, hold time not applicable
    cyc(1);
    chk_b(cts_pin, 1'b0);
    chk_b(rx_ready, 1'b1);
    rd(`REG_HOLD);
    chk_w(rd_w, 32'h10000);
    rd(`REG_SECURITY);
    chk_w(rd_w, 32'h0);
    rd(`REG_CTRL);
    chk_w(rd_w, 32'h0);
    done("reset");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk_w(rd_w, rows[i].e);
    end
    done("registers");
    // Remote: adopts broadcast setting, refuses local change, code match
    wr(`REG_CTRL, 32'h0);
    wr(`REG_SECURITY, 32'h5a);
    cyc(1);
    chk_b(encrypt_en, 1'b1);
    sync(8'h5a, 1'b0);
    chk_b(synced, 1'b1);
    @(posedge clk) bcast_valid <= 1'b1;
    bcast_buffer_mode <= 1'b1;
    @(posedge clk) bcast_valid <= 1'b0;
    rd(`REG_CTRL);
    chk_w(rd_w, 32'h1);
    wr(`REG_CTRL, 32'h0);
    rd(`REG_CTRL);
    chk_w(rd_w, 32'h1);
    sync(8'h33, 1'b0);
    chk_b(synced, 1'b0);
    sync(8'h5a, 1'b0);
    sync(8'h00, 1'b1);
    chk_b(synced, 1'b0);
    wr(`REG_SECURITY, 32'h0);
    cyc(1);
    chk_b(encrypt_en, 1'b0);
    done("security");
    // Port characters key the radio alike under either buffer setting
    wr(`REG_CTRL, 32'h4);
    for (int b = 0; b < 2; b++) begin
      wr(`REG_CTRL, 32'h4 | word_t'(b));
      @(posedge clk) port_rx_valid <= 1'b1;
      @(posedge clk) port_rx_valid <= 1'b0;
      #1 chk_b(key_tx, 1'b1);
    end
    // Unbuffered: a byte shows the cycle after it arrives
    wr(`REG_CTRL, 32'h4);
    send(1, 1'b1);
    #1 chk_b(out_valid, 1'b1);
    send(3, 1'b1);
    drain();
    // Terminal held off: fill the FIFO until it refuses, then drain
    // The eighth byte closes the packet so no release is left pending
    @(posedge clk) stall <= 1'b1;
    send(8, 1'b1);
    #1 chk_b(rx_ready, 1'b0);
    @(posedge clk) stall <= 1'b0;
    drain();
    cyc(1);
    chk_b(rx_ready, 1'b1);
    done("unbuffered");
    // Buffered: nothing leaves before the last byte, then no gaps
    wr(`REG_CTRL, 32'h5);
    send(3, 1'b0);
    cyc(10);
    chk_b(out_valid, 1'b0);
    send(2, 1'b1);
    gaps = 0;
    repeat (20) begin
      cyc(1);
      if (partner_u.got.size() < 5 && out_valid !== 1'b1) gaps++;
    end
    chk_w(word_t'(gaps), 32'h0);
    drain();
    done("buffered");
    // Modem: CTS after 2 ms of RTS, drops while the radio lags
    wr(`REG_CTRL, 32'h4);
    wr(`REG_CTS_DELAY, 32'h2);
    @(posedge clk) rts_req <= 1'b1;
    cyc(8);
    chk_b(cts_pin, 1'b0);
    cyc(7);
    chk_b(cts_pin, 1'b1);
    @(posedge clk) radio_tx_ready <= 1'b0;
    cyc(2);
    chk_b(cts_pin, 1'b0);
    @(posedge clk) radio_tx_ready <= 1'b1;
    @(posedge clk) rts_req <= 1'b0;
    wr(`REG_CTS_DELAY, 32'h0);
    cyc(4);
    @(posedge clk) rts_req <= 1'b1;
    cyc(6);
    chk_b(cts_pin, 1'b1);
    @(posedge clk) rts_req <= 1'b0;
    done("modem");
    // Keyline: RTS ignored, CTS keys on data, output waits, CTS holds
    wr(`REG_CTRL, 32'h6);
    wr(`REG_HOLD, 32'h11170);
    rd(`REG_HOLD);
    chk_w(rd_w, 32'hea60);
    wr(`REG_HOLD, 32'h1);
    wr(`REG_CTS_DELAY, 32'h1);
    @(posedge clk) rts_req <= 1'b1;
    cyc(8);
    chk_b(cts_pin, 1'b0);
    send(1, 1'b1);
    #1 chk_b(cts_pin, 1'b1);
    chk_b(out_valid, 1'b0);
    drain();
    cyc(3);
    chk_b(cts_pin, 1'b1);
    cyc(9);
    chk_b(cts_pin, 1'b0);
    @(posedge clk) rts_req <= 1'b0;
    // Zero hold: CTS drops as soon as the port goes idle
    wr(`REG_HOLD, 32'h0);
    send(1, 1'b1);
    drain();
    cyc(8);
    chk_b(cts_pin, 1'b0);
    done("keyline");
    wrap_up();
  end
endmodule
